// *** dfo_main.sv ***
// diagnostic flag registers and output command registers behind the serial frame port
//
// Operation
// RL1: reg 1011b bits 7..4 latch over-temperature of supplies, stages, relay driver, regulator.
// RL2: reg 1011b bit 3 latches 5 V undervoltage reset, even when masked.
// RL3: reg 1011b bit 2 shows live CAN transceiver error condition.
// RL4: reg 1011b bit 1 sets on a received frame of wrong length.
// RL5: reg 1011b bit 0 sets when no frame arrives within timeout.
// RL6: reg 0000b bit 7 sets after I/O supply low beyond 225 ms.
// RL7: reg 0000b watchdog reset: bit 6 latched, bit 3 live copy.
// RL8: reg 0000b bit 5 flags injectors 1-4 switched off after 225 ms.
// RL9: reg 0000b bit 4 flags relays 13,14 off 600 ms after key off.
// RL10: engine-off flags only with power latch disabled; key low or watchdog triggers.
// RL11: reg 0000b bits 2,1 read zero; bit 0 is filtered key state.
// RL12: command 7 returns reg 0000b; only command 5 clears its flags.
// RL13: data frames have D0 zero, control data from D1 upward.
// RL14: command bit 1 switches stage on; registers reset to zero.
// RL15: control 1 bits 7..0 drive stages 1,2,3,4,5,20,8,19.
// RL16: control 2 drives 15,14, ignores bit 5, then 9, ignitions 1-4.
// RL17: control 3 bits 7..0 drive stages 22,21,16,13,17,18,7,6.
// RL18: stepper mode: control 3 bit 6 enables stepper, bit 7 direction.
// RL19: reg 1011b flags clear when their register is read.
// RL20: while global output disable is set, control data is ignored.
// RL21: stepper direction bit 0 forward, 1 backward.
// RL22: unused control 2 bit 5 never reaches any stage or state.
`timescale 1ns/100ps
`include "dfo_regs.svh"
module dfo_main #(
    parameter int unsigned IO_LOW_CYCLES    = `DFO_IO_LOW_MS * `DFO_CYC_PER_MS,
    parameter int unsigned SEO_INJ_CYCLES   = `DFO_SEO_INJ_MS * `DFO_CYC_PER_MS,
    parameter int unsigned SEO_RELAY_CYCLES = `DFO_SEO_RELAY_MS * `DFO_CYC_PER_MS,
    parameter int unsigned TIMEOUT_CYCLES   = `DFO_FRAME_TIMEOUT_MS * `DFO_CYC_PER_MS
) (
    input  wire logic                     CLK_SYS,
    input  wire logic                     RST,
    input  wire logic                     DS_VALID,
    input  wire logic [`DFO_FRAME_W-1:0]  DS_FRAME,
    input  wire logic                     FRAME_LEN_ERR,
    input  wire dfo_pkg::dfo_sense_t      SENSE,
    input  wire logic                     STEP_MODE,
    input  wire logic                     POWER_LATCH_EN,
    output logic                          REPLY_VALID,
    output logic [7:0]                    REPLY_DATA,
    output logic                          OUT_DISABLED,
    output dfo_pkg::dfo_stage_t           STAGES
);
    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        dfo_pkg::dfo_sense_t sense_d;
        logic [7:0]          temp_flags;
        logic [7:4]          event_flags;
        logic [7:0]          ctrl1;
        logic [7:0]          ctrl2;
        logic [7:0]          ctrl3;
        logic                global_output_disable;
        logic                seo_arm;
        logic                inj_off;
        logic                relay_off;
        logic                reply_valid;
        logic [7:0]          reply_data;
        dfo_pkg::dfo_stage_t stages;
    } dfo_main_state_t;

    dfo_main_state_t     st_r;
    dfo_main_state_t     st_nxt;
    dfo_pkg::dfo_sense_t sense_f;
    logic                io_low_done;
    logic                inj_done;
    logic                relay_done;
    logic                timeout_done;

    // ************************************************
    // input conditioning and delay timers
    // ************************************************
    dfo_sync_filter u_sync (
        .CLK_SYS   (CLK_SYS),
        .RST       (RST),
        .sense_in  (SENSE),
        .sense_out (sense_f)
    );

    dfo_delay_timer #(.CYCLES(IO_LOW_CYCLES)) u_io_low (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .run     (sense_f.io_supply_low),
        .done    (io_low_done)
    );

    dfo_delay_timer #(.CYCLES(SEO_INJ_CYCLES)) u_seo_inj (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .run     (st_r.seo_arm),
        .done    (inj_done)
    );

    dfo_delay_timer #(.CYCLES(SEO_RELAY_CYCLES)) u_seo_relay (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .run     (st_r.seo_arm),
        .done    (relay_done)
    );

    // restarts on every frame so silence is measured from the last one
    dfo_delay_timer #(.CYCLES(TIMEOUT_CYCLES)) u_timeout (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .run     (!DS_VALID),
        .done    (timeout_done)
    );

    // ************************************************
    // frame decode
    // ************************************************
    logic       is_data;
    logic       is_cmd;
    logic [3:0] cmd_code;
    logic [7:0] frame_data;
    logic [1:0] reg_sel;
    logic       rd_temp;
    logic       rd_events;
    logic       clr_events;

    assign is_data    = DS_VALID && !DS_FRAME[`DFO_FRAME_SEL_BIT]; // RL13
    assign is_cmd     = DS_VALID && DS_FRAME[`DFO_FRAME_SEL_BIT];
    assign cmd_code   = DS_FRAME[`DFO_FRAME_CMD_LSB +: 4];
    assign frame_data = DS_FRAME[`DFO_FRAME_DATA_LSB +: 8]; // RL13
    assign reg_sel    = DS_FRAME[`DFO_FRAME_REGSEL_LSB +: 2];
    assign rd_temp    = is_cmd && (cmd_code == `DFO_ADDR_TEMP_LINK);
    assign rd_events  = is_cmd && (cmd_code == `DFO_CMD_READ_EVENTS);
    assign clr_events = is_cmd && (cmd_code == `DFO_CMD_CLEAR_EVENTS);

    function automatic logic [7:0] event_view(input dfo_main_state_t s, input dfo_pkg::dfo_sense_t f);
        event_view = {s.event_flags, f.watchdog_reset, 2'b00, f.key_on}; // RL7 RL11
    endfunction : event_view

    function automatic dfo_pkg::dfo_stage_t stage_map(input dfo_main_state_t s, input logic step);
        stage_map          = '0;
        stage_map.injector = {s.ctrl1[4], s.ctrl1[5], s.ctrl1[6], s.ctrl1[7]}; // RL15
        stage_map.out5     = s.ctrl1[3]; // RL15
        stage_map.out20    = s.ctrl1[2];
        stage_map.out8     = s.ctrl1[1];
        stage_map.out19    = s.ctrl1[0];
        stage_map.out15    = s.ctrl2[7]; // RL16
        stage_map.out14    = s.ctrl2[6];
        // bit 4 taken as stage 9, bit 3 as ignition 1
        stage_map.out9     = s.ctrl2[4]; // RL16
        stage_map.ignition = {s.ctrl2[0], s.ctrl2[1], s.ctrl2[2], s.ctrl2[3]};
        stage_map.out16    = s.ctrl3[5]; // RL17
        stage_map.out13    = s.ctrl3[4];
        stage_map.out17    = s.ctrl3[3];
        stage_map.out18    = s.ctrl3[2];
        stage_map.out7     = s.ctrl3[1];
        stage_map.out6     = s.ctrl3[0];
        if (step)
        begin
            stage_map.step_en  = s.ctrl3[6]; // RL18
            stage_map.step_dir = s.ctrl3[7]; // RL21
        end
        else
        begin
            stage_map.out22 = s.ctrl3[7]; // RL17
            stage_map.out21 = s.ctrl3[6];
        end
        // secure engine-off overrides the host command
        if (s.inj_off)
            stage_map.injector = 4'h0; // RL8
        if (s.relay_off)
        begin
            stage_map.out13 = 1'b0; // RL9
            stage_map.out14 = 1'b0;
        end
    endfunction : stage_map

    // ************************************************
    // next state
    // ************************************************
    logic [7:0] temp_set;
    logic [7:4] event_set;
    logic       key_fell;
    logic       key_rose;
    logic       wdg_rose;

    always_comb
    begin
        st_nxt   = st_r;
        key_fell = st_r.sense_d.key_on && !sense_f.key_on;
        key_rose = !st_r.sense_d.key_on && sense_f.key_on;
        wdg_rose = !st_r.sense_d.watchdog_reset && sense_f.watchdog_reset;
        st_nxt.sense_d = sense_f;

        temp_set = {sense_f.sensor_supply_overtemp & ~st_r.sense_d.sensor_supply_overtemp, // RL1
                    sense_f.stage_overtemp & ~st_r.sense_d.stage_overtemp,
                    sense_f.relay_driver_overtemp & ~st_r.sense_d.relay_driver_overtemp,
                    sense_f.low_reg_overtemp & ~st_r.sense_d.low_reg_overtemp,
                    sense_f.supply5_uv_reset & ~st_r.sense_d.supply5_uv_reset, // RL2
                    1'b0,
                    FRAME_LEN_ERR, // RL4
                    timeout_done}; // RL5
        event_set = {io_low_done, // RL6
                     wdg_rose, // RL7
                     inj_done && st_r.seo_arm, // RL8
                     relay_done && st_r.seo_arm}; // RL9

        // read clears, a coincident event still lands
        if (rd_temp)
            st_nxt.temp_flags = temp_set; // RL19
        else
            st_nxt.temp_flags = st_r.temp_flags | temp_set;
        if (clr_events)
            st_nxt.event_flags = event_set; // RL12
        else
            st_nxt.event_flags = st_r.event_flags | event_set;

        st_nxt.reply_valid = rd_temp || rd_events || clr_events;
        if (rd_temp)
            st_nxt.reply_data = {st_r.temp_flags[7:3], sense_f.can_error, st_r.temp_flags[1:0]}; // RL3
        else if (rd_events || clr_events)
            st_nxt.reply_data = event_view(st_r, sense_f); // RL12
        else
            st_nxt.reply_data = st_r.reply_data;

        if (is_cmd && cmd_code == `DFO_CMD_START)
            st_nxt.global_output_disable = 1'b0; // RL20

        if (is_data && !st_r.global_output_disable) // RL20
        begin
            unique case (reg_sel)
                `DFO_REGSEL_CTRL1: st_nxt.ctrl1 = frame_data;
                `DFO_REGSEL_CTRL2: st_nxt.ctrl2 = frame_data & ~(8'h01 << `DFO_CTRL2_UNUSED_BIT); // RL22
                `DFO_REGSEL_CTRL3: st_nxt.ctrl3 = frame_data;
                default:           st_nxt.ctrl1 = st_r.ctrl1;
            endcase
        end

        // engine-off delay is armed only with the power latch disabled
        if (!POWER_LATCH_EN && (key_fell || wdg_rose)) // RL10
            st_nxt.seo_arm = 1'b1;
        if (inj_done && st_r.seo_arm)
            st_nxt.inj_off = 1'b1; // RL8
        if (relay_done && st_r.seo_arm)
        begin
            st_nxt.relay_off = 1'b1; // RL9
            st_nxt.seo_arm   = 1'b0;
        end
        if (key_rose)
        begin
            st_nxt.seo_arm   = 1'b0;
            st_nxt.inj_off   = 1'b0;
            st_nxt.relay_off = 1'b0;
        end

        st_nxt.stages = stage_map(st_nxt, STEP_MODE); // RL14
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            st_r             <= '0; // RL14
            st_r.temp_flags  <= `DFO_FLAGS_RESET;
            st_r.ctrl1       <= `DFO_CTRL_RESET;
            st_r.ctrl2       <= `DFO_CTRL_RESET;
            st_r.ctrl3       <= `DFO_CTRL_RESET;
            st_r.global_output_disable     <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign REPLY_VALID  = st_r.reply_valid;
    assign REPLY_DATA   = st_r.reply_data;
    assign OUT_DISABLED = st_r.global_output_disable;
    assign STAGES       = st_r.stages;

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    property p_ot_latch;
        (sense_f.sensor_supply_overtemp && !st_r.sense_d.sensor_supply_overtemp) |=> st_r.temp_flags[7];
    endproperty
    a_ot_latch: assert property (p_ot_latch) else $error("overtemp not latched"); // RL1

    property p_uv_latch;
        (sense_f.supply5_uv_reset && !st_r.sense_d.supply5_uv_reset) |=> st_r.temp_flags[3];
    endproperty
    a_uv_latch: assert property (p_uv_latch) else $error("5 V reset event not latched"); // RL2

    property p_can_live;
        rd_temp |=> REPLY_VALID && (REPLY_DATA[2] == $past(sense_f.can_error));
    endproperty
    a_can_live: assert property (p_can_live) else $error("CAN bit not live"); // RL3

    property p_len_err;
        FRAME_LEN_ERR |=> st_r.temp_flags[1] [*1] ##1 (st_r.temp_flags[1] || $past(rd_temp));
    endproperty
    a_len_err: assert property (p_len_err) else $error("length error lost"); // RL4

    property p_timeout;
        timeout_done |=> st_r.temp_flags[0];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag missing"); // RL5

    property p_io_low;
        io_low_done |=> st_r.event_flags[7];
    endproperty
    a_io_low: assert property (p_io_low) else $error("io supply flag missing"); // RL6

    property p_read7_keeps;
        (rd_events && event_set == 4'h0) |=> st_r.event_flags == $past(st_r.event_flags);
    endproperty
    a_read7_keeps: assert property (p_read7_keeps) else $error("read 7 altered flags"); // RL12

    property p_read_clear;
        (rd_temp && !FRAME_LEN_ERR && !timeout_done) |=> st_r.temp_flags[1:0] == 2'b00;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear"); // RL19

    property p_disabled_ignores;
        (is_data && st_r.global_output_disable) |=> {st_r.ctrl1, st_r.ctrl2, st_r.ctrl3} == $past({st_r.ctrl1, st_r.ctrl2, st_r.ctrl3});
    endproperty
    a_disabled_ignores: assert property (p_disabled_ignores) else $error("write taken while disabled"); // RL20

    property p_unused_bit;
        is_data |=> st_r.ctrl2[`DFO_CTRL2_UNUSED_BIT] == 1'b0;
    endproperty
    a_unused_bit: assert property (p_unused_bit) else $error("unused bit stored"); // RL22

    property p_stepper;
        ##1 $past(STEP_MODE) |-> (STAGES.step_en == st_r.ctrl3[6]) && (STAGES.step_dir == st_r.ctrl3[7])
            && !STAGES.out22 && !STAGES.out21;
    endproperty
    a_stepper: assert property (p_stepper) else $error("stepper mapping wrong"); // RL18

    property p_seo_inj;
        (inj_done && st_r.seo_arm) |=> st_r.event_flags[5] && (STAGES.injector == 4'h0 || $past(key_rose));
    endproperty
    a_seo_inj: assert property (p_seo_inj) else $error("injector engine-off missing"); // RL8

    property p_seo_gate;
        (POWER_LATCH_EN && !st_r.seo_arm) |=> !st_r.seo_arm;
    endproperty
    a_seo_gate: assert property (p_seo_gate) else $error("engine-off armed with latch on"); // RL10

    c_start:   cover property (is_cmd && cmd_code == `DFO_CMD_START ##1 is_data);
    c_seo:     cover property (relay_done && st_r.seo_arm);
    c_read11:  cover property (rd_temp && FRAME_LEN_ERR);
    c_clear5:  cover property (clr_events ##1 REPLY_VALID);
endmodule : dfo_main

// *** dfo_regs.svh ***
// register offsets, command codes, field positions, reset values and timing counts
`ifndef DFO_REGS_SVH
`define DFO_REGS_SVH

// ************************************************
// register addresses and command codes
// ************************************************
`define DFO_ADDR_EVENT_FLAGS    4'h0
`define DFO_ADDR_TEMP_LINK      4'hB
`define DFO_CMD_READ_EVENTS     4'h7
`define DFO_CMD_CLEAR_EVENTS    4'h5
`define DFO_CMD_START           4'h1

// ************************************************
// downstream frame layout
// ************************************************
`define DFO_FRAME_W             16
`define DFO_FRAME_SEL_BIT       0
`define DFO_FRAME_DATA_LSB      1
`define DFO_FRAME_CMD_LSB       1
`define DFO_FRAME_REGSEL_LSB    9
`define DFO_REGSEL_CTRL1        2'h1
`define DFO_REGSEL_CTRL2        2'h2
`define DFO_REGSEL_CTRL3        2'h3

// ************************************************
// field positions and reset values
// ************************************************
`define DFO_CTRL2_UNUSED_BIT    5
`define DFO_CTRL_RESET          8'h00
`define DFO_FLAGS_RESET         8'h00

// ************************************************
// timing
// ************************************************
`define DFO_CLK_HZ              10000000
`define DFO_CYC_PER_MS          (`DFO_CLK_HZ / 1000)
`define DFO_IO_LOW_MS           225
`define DFO_SEO_INJ_MS          225
`define DFO_SEO_RELAY_MS        600
`define DFO_FRAME_TIMEOUT_MS    20

`endif

// *** dfo_pkg.sv ***
// types shared by the diagnostic flag and output command bank
package dfo_pkg;

    typedef struct packed {
        logic sensor_supply_overtemp;
        logic stage_overtemp;
        logic relay_driver_overtemp;
        logic low_reg_overtemp;
        logic supply5_uv_reset;
        logic can_error;
        logic watchdog_reset;
        logic key_on;
        logic io_supply_low;
    } dfo_sense_t;

    typedef struct packed {
        logic [3:0] injector;
        logic       out5;
        logic       out20;
        logic       out8;
        logic       out19;
        logic       out15;
        logic       out14;
        logic       out9;
        logic [3:0] ignition;
        logic       out22;
        logic       out21;
        logic       out16;
        logic       out13;
        logic       out17;
        logic       out18;
        logic       out7;
        logic       out6;
        logic       step_en;
        logic       step_dir;
    } dfo_stage_t;

endpackage : dfo_pkg

// *** dfo_sync_filter.sv ***
// three-stage synchroniser with agreement filter for the analogue status levels
`timescale 1ns/100ps
module dfo_sync_filter (
    input  wire logic                CLK_SYS,
    input  wire logic                RST,
    input  wire dfo_pkg::dfo_sense_t sense_in,
    output dfo_pkg::dfo_sense_t      sense_out
);
    typedef struct packed {
        dfo_pkg::dfo_sense_t s1;
        dfo_pkg::dfo_sense_t s2;
        dfo_pkg::dfo_sense_t s3;
        dfo_pkg::dfo_sense_t filt;
    } dfo_sync_state_t;

    dfo_sync_state_t st_r;
    dfo_sync_state_t st_nxt;

    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = sense_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // a bit moves only once the two late stages agree
        st_nxt.filt = (st_r.s2 & st_r.s3) | (st_r.filt & (st_r.s2 ^ st_r.s3));
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign sense_out = st_r.filt;
endmodule : dfo_sync_filter

// *** dfo_delay_timer.sv ***
// delay counter: one-cycle done pulse after run has stayed high for CYCLES edges
`timescale 1ns/100ps
module dfo_delay_timer #(
    parameter int unsigned CYCLES = 1
) (
    input  wire logic CLK_SYS,
    input  wire logic RST,
    input  wire logic run,
    output logic      done
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        done;
    } dfo_timer_state_t;

    dfo_timer_state_t st_r;
    dfo_timer_state_t st_nxt;

    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (!run)
            st_nxt.cnt = 32'h0;
        // stops at the end so a held level fires only once
        else if (st_r.cnt < CYCLES)
        begin
            st_nxt.cnt  = st_r.cnt + 32'h1;
            st_nxt.done = (st_r.cnt == CYCLES - 32'h1);
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign done = st_r.done;
endmodule : dfo_delay_timer

// *** dfo_host_model.sv ***
// host side frame source for the diagnostic flag and output command bank
`timescale 1ns/100ps
module dfo_host_model (
    input  wire logic        CLK_SYS,
    output logic             DS_VALID,
    output logic [15:0]      DS_FRAME
);
    initial
    begin
        DS_VALID = 1'b0;
        DS_FRAME = 16'h0000;
    end

    // frame line is not held after the pulse: inverse of last value
    task automatic send(input logic [15:0] f);
        @(posedge CLK_SYS);
        DS_VALID <= 1'b1;
        DS_FRAME <= f;
        @(posedge CLK_SYS);
        DS_VALID <= 1'b0;
        DS_FRAME <= ~f;
    endtask : send

    task automatic data(input logic [1:0] t, input logic [7:0] d);
        send({5'h00, t, d, 1'b0});
    endtask : data

    task automatic cmd(input logic [3:0] c);
        send({11'h000, c, 1'b1});
    endtask : cmd
endmodule : dfo_host_model

// *** test_diag_flags_and_output_command_regs.sv ***
// self-checking bench for the diagnostic flag and output command bank
`timescale 1ns/100ps
`include "dfo_regs.svh"
module test_diag_flags_and_output_command_regs;
    logic                clk_sys;
    logic                rst            = 1'b1;
    logic                frame_len_err  = 1'b0;
    logic                step_mode      = 1'b0;
    logic                power_latch_en = 1'b1;
    dfo_pkg::dfo_sense_t sense;
    wire logic           ds_valid;
    wire logic [15:0]    ds_frame;
    logic                reply_valid;
    logic [7:0]          reply_data;
    logic                out_disabled;
    dfo_pkg::dfo_stage_t stages;
    logic [7:0]          q[$];
    int                  err_count = 0;
    int                  compares  = 0;
    int                  cyc       = 0;
    logic [7:0]          c1, c2, c3, ot;

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    dfo_host_model host (.CLK_SYS(clk_sys), .DS_VALID(ds_valid), .DS_FRAME(ds_frame));

    // short counts keep the run small
    dfo_main #(.IO_LOW_CYCLES(20), .SEO_INJ_CYCLES(20), .SEO_RELAY_CYCLES(50), .TIMEOUT_CYCLES(2000)) DUT (
        .CLK_SYS(clk_sys), .RST(rst), .DS_VALID(ds_valid), .DS_FRAME(ds_frame),
        .FRAME_LEN_ERR(frame_len_err), .SENSE(sense), .STEP_MODE(step_mode),
        .POWER_LATCH_EN(power_latch_en), .REPLY_VALID(reply_valid), .REPLY_DATA(reply_data),
        .OUT_DISABLED(out_disabled), .STAGES(stages));

    // ************************************************
    // helpers
    // ************************************************
    task automatic test_done;
        $display("err_count=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic cmp(input logic [24:0] got, input logic [24:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    function automatic dfo_pkg::dfo_stage_t exp_st(logic [7:0] a, logic [7:0] b, logic [7:0] c, logic sm);
        dfo_pkg::dfo_stage_t s;
        s = '0;
        s.injector = {a[4], a[5], a[6], a[7]};
        {s.out5, s.out20, s.out8, s.out19} = a[3:0];
        {s.out15, s.out14, s.out9} = {b[7:6], b[4]};
        s.ignition = {b[0], b[1], b[2], b[3]};
        {s.out22, s.out21} = c[7:6] & {2{~sm}};
        {s.out16, s.out13, s.out17, s.out18, s.out7, s.out6} = c[5:0];
        {s.step_dir, s.step_en} = c[7:6] & {2{sm}};
        return s;
    endfunction : exp_st

    task automatic rd(input logic [3:0] code, input logic [7:0] exp);
        q.push_back(exp);
        host.cmd(code);
    endtask : rd

    task automatic chk_st(input dfo_pkg::dfo_stage_t exp);
        #1;
        cmp(stages, exp);
    endtask : chk_st

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle

    // replies are matched against the oldest note
    always @(posedge clk_sys)
    begin
        cyc++;
        if (reply_valid === 1'b1)
        begin
            if (q.size() == 0)
                cmp(25'h1, 25'h0);
            else
                cmp(25'(reply_data), 25'(q.pop_front()));
        end
        if (cyc == 6000)
        begin
            err_count++;
            test_done();
        end
    end

    // ************************************************
    // scenarios
    // ************************************************
    initial
    begin
        void'($urandom(2251));
        sense = '0;
        sense.key_on = 1'b1;
        idle(4);
        rst <= 1'b0;
        idle(1);
        chk_st('0);
        cmp(25'(out_disabled), 25'h1);
        host.data(2'h1, 8'hFF);
        chk_st('0);
        host.cmd(`DFO_CMD_START);
        #1 cmp(25'(out_disabled), 25'h0);
        c1 = 8'($urandom);
        c2 = 8'($urandom);
        c3 = 8'($urandom);
        host.data(2'h1, c1);
        host.data(2'h2, c2 | 8'h20);
        host.data(2'h3, c3);
        host.data(2'h0, 8'hFF);
        chk_st(exp_st(c1, c2, c3, 1'b0));
        @(posedge clk_sys);
        step_mode <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            c3[7:6] = 2'(i);
            host.data(2'h3, c3);
            idle(1);
            chk_st(exp_st(c1, c2, c3, 1'b1));
        end
        @(posedge clk_sys);
        step_mode <= 1'b0;
        host.cmd(4'h3);
        ot = 8'($urandom) | 8'h09;
        @(posedge clk_sys);
        {sense.sensor_supply_overtemp, sense.stage_overtemp, sense.relay_driver_overtemp,
         sense.low_reg_overtemp, sense.supply5_uv_reset, sense.can_error} <= {ot[3:0], 2'b11};
        frame_len_err <= 1'b1;
        @(posedge clk_sys);
        frame_len_err <= 1'b0;
        idle(6);
        rd(`DFO_ADDR_TEMP_LINK, {ot[3:0], 4'b1110});
        rd(`DFO_ADDR_TEMP_LINK, 8'h04);
        @(posedge clk_sys);
        {sense.sensor_supply_overtemp, sense.stage_overtemp, sense.relay_driver_overtemp,
         sense.low_reg_overtemp, sense.supply5_uv_reset, sense.can_error} <= 6'h00;
        idle(6);
        rd(`DFO_ADDR_TEMP_LINK, 8'h00);
        sense.watchdog_reset <= 1'b1;
        idle(6);
        rd(`DFO_CMD_READ_EVENTS, 8'h49);
        rd(`DFO_CMD_READ_EVENTS, 8'h49);
        rd(`DFO_CMD_CLEAR_EVENTS, 8'h49);
        rd(`DFO_CMD_READ_EVENTS, 8'h09);
        sense.watchdog_reset <= 1'b0;
        power_latch_en <= 1'b0;
        host.data(2'h1, 8'hF0);
        host.data(2'h2, 8'h40);
        host.data(2'h3, 8'h10);
        chk_st(exp_st(8'hF0, 8'h40, 8'h10, 1'b0));
        @(posedge clk_sys);
        sense.key_on <= 1'b0;
        idle(30);
        chk_st(exp_st(8'h00, 8'h40, 8'h10, 1'b0));
        idle(30);
        chk_st('0);
        rd(`DFO_CMD_READ_EVENTS, 8'h30);
        sense.key_on <= 1'b1;
        idle(8);
        chk_st(exp_st(8'hF0, 8'h40, 8'h10, 1'b0));
        @(posedge clk_sys);
        sense.io_supply_low <= 1'b1;
        idle(30);
        rd(`DFO_CMD_CLEAR_EVENTS, 8'hB1);
        sense.io_supply_low <= 1'b0;
        // watchdog alone arms engine-off while the key stays high
        sense.watchdog_reset <= 1'b1;
        idle(30);
        chk_st(exp_st(8'h00, 8'h40, 8'h10, 1'b0));
        idle(2010);
        rd(`DFO_ADDR_TEMP_LINK, 8'h01);
        idle(4);
        cmp(25'(q.size()), 25'h0);
        // mid-run reset must drop every stage and disable outputs again
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        idle(1);
        chk_st('0);
        cmp(25'(out_disabled), 25'h1);
        test_done();
    end
endmodule : test_diag_flags_and_output_command_regs
